/* hmc_mode_ctrl.sv */
// hmc_mode_ctrl: mode control and realtime drive value register bank
// of a haptic actuator driver, apb slave, trigger pin handling.
// assumes a playback/diagnostic engine outside that reports done.
//
// Function
// - soft reset bit stops playback, restores defaults
// - soft reset bit self-clears when reset ends
// - standby bit defaults one; one means standby
// - mode bits 2-0 default zero; host launches
// - edge mode: trigger rising edge sets launch
// - edge mode: second rising edge cancels waveform
// - level mode: launch follows trigger, fall cancels
// - level mode: redundant edge changes nothing
// - mode 3 drives from pwm or analog
// - mode 4 audio drive; host sets input bits
// - mode 5 drives realtime drive value
// - diagnostic: launch clears at end, outcome stored
// - calibration: launch self-clears when complete
// - drive value eight-bit read-write, resets zero
// - drive value signed unless format bit set
// - outcome flag holds last result, clears on read
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module hmc_mode_ctrl
    import hmc_pkg::*;
#(
    parameter int RST_CYCLES = HMC_SOFT_RST_CYCLES // soft reset duration
)
(
    input  wire logic         clk_sys_i,         // system clock, 10 MHz
    input  wire logic         rst_i,             // async reset, active high
    input  wire logic         psel,              // apb select
    input  wire logic         penable,           // apb access phase
    input  wire logic         pwrite,            // apb write
    input  wire logic [11:0]  paddr,             // apb byte address
    input  wire logic [31:0]  pwdata,            // apb write data
    output logic      [31:0]  prdata,            // apb read data
    output logic              pready,            // apb ready
    output logic              pslverr,           // apb error, unmapped
    input  wire logic         trigger_input_pin, // asynchronous trigger pin
    input  wire logic         routine_done_i,    // engine finished, pulse
    input  wire logic         routine_fail_i,    // result with done pulse
    output logic              launch_o,          // launch bit level
    output logic              cancel_o,          // cancel pulse to engine
    output hmc_pkg::hmc_mode_type mode_o,        // current mode
    output logic              standby_o,         // software standby
    output logic              drive_active_o,    // pin or value drives load
    output logic              drive_analog_o,    // pin source is analog
    output logic              dc_block_o,        // input dc block enable
    output logic      [7:0]   drive_value_o,     // realtime value to load
    output logic              drive_unsigned_o,  // value taken as unsigned
    output logic              playback_stop_o    // playback halted by reset
);
    import hmc_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic         standby_r;  // software standby bit
    hmc_mode_type mode_r;     // mode field
    logic [7:0]   rtv_r;      // realtime drive value
    logic         launch_r;   // launch bit
    logic [2:0]   incfg_r;    // input kind, dc block, value format
    logic         outcome_r;  // routine outcome flag
    logic         rd_out_r;   // outcome value captured for a read
    logic         soft_clr;   // registers held at defaults
    logic         soft_busy;  // soft reset bit reads one
    logic         soft_start; // write of one to soft reset bit
    logic         trig_lvl;   // synchronised trigger level
    logic         trig_rise;  // accepted rising change
    logic         trig_fall;  // accepted falling change
    logic         launch_nxt; // launch bit next value
    logic         cancel_nxt; // cancel pulse next value

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic         setup_ph;  // apb setup cycle
    logic         acc_done;  // access phase completes this edge
    logic         wr_en;     // write takes effect
    logic         rd_en;     // read completes
    logic [7:0]   idx;       // register index from byte address
    logic         addr_ok;   // address maps a register

    // true when the byte address is the word of the given index
    function automatic logic hit(input logic [11:0] a, input logic [7:0] i);
        hit = (a[11:2] == {2'b00, i}) && (a[1:0] == 2'b00);
    endfunction

    assign setup_ph = psel && !penable;
    assign acc_done = psel && penable && pready;
    assign wr_en    = acc_done && pwrite && !pslverr;
    assign rd_en    = acc_done && !pwrite && !pslverr;
    assign idx      = paddr[9:2];
    assign addr_ok  = hit(paddr, HMC_IDX_STATUS) || hit(paddr, HMC_IDX_MODE) ||
                      hit(paddr, HMC_IDX_RTV) || hit(paddr, HMC_IDX_LAUNCH) ||
                      hit(paddr, HMC_IDX_INCFG);
    assign soft_start = wr_en && hit(paddr, HMC_IDX_MODE) && pwdata[HMC_BIT_SOFT_RST]
                        && !soft_busy;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    hmc_pin_sync u_trig_sync
    (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pin_i     (trigger_input_pin),
        .level_o   (trig_lvl),
        .rise_o    (trig_rise),
        .fall_o    (trig_fall)
    );

    hmc_reset_seq #(.CYCLES(RST_CYCLES)) u_soft_rst
    (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .start_i   (soft_start),
        .clear_o   (soft_clr),
        .busy_o    (soft_busy)
    );

    // ------------------------------------------------------------------
    // apb handshake: no wait state, data prepared in the setup cycle
    // ------------------------------------------------------------------
    // preparing read data a cycle early keeps prdata a plain flop output
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0000_0000;
            rd_out_r <= 1'b0;
        end
        else
        begin
            pready  <= setup_ph;
            pslverr <= setup_ph && !addr_ok;
            if (setup_ph && !pwrite)
            begin
                rd_out_r <= hit(paddr, HMC_IDX_STATUS) && outcome_r;
                case (idx)
                    HMC_IDX_STATUS: prdata <= 32'(outcome_r) << HMC_BIT_OUTCOME;
                    HMC_IDX_MODE:   prdata <= {24'h000000, soft_busy, standby_r,
                                               3'h0, mode_r};
                    HMC_IDX_RTV:    prdata <= {24'h000000, rtv_r};
                    HMC_IDX_LAUNCH: prdata <= {31'h00000000, launch_r};
                    HMC_IDX_INCFG:  prdata <= {28'h0000000, incfg_r[2], 1'b0,
                                               incfg_r[1:0]};
                    default:        prdata <= 32'h0000_0000;
                endcase
            end
            else if (setup_ph)
            begin
                prdata <= 32'h0000_0000; // writes return zero
            end
        end
    end

    // ------------------------------------------------------------------
    // mode control register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            standby_r <= HMC_RST_STANDBY;
            mode_r    <= HMC_MODE_INTERNAL;
        end
        else if (soft_clr || soft_start)
        begin
            standby_r <= HMC_RST_STANDBY;
            mode_r    <= hmc_mode_type'(HMC_RST_MODE);
        end
        else if (wr_en && hit(paddr, HMC_IDX_MODE))
        begin
            standby_r <= pwdata[HMC_BIT_STANDBY];
            mode_r    <= hmc_mode_type'(pwdata[HMC_MODE_MSB:0]);
        end
    end

    // ------------------------------------------------------------------
    // realtime drive value and input configuration
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rtv_r   <= HMC_RST_RTV;
            incfg_r <= HMC_RST_INCFG;
        end
        else if (soft_clr || soft_start)
        begin
            rtv_r   <= HMC_RST_RTV;
            incfg_r <= HMC_RST_INCFG;
        end
        else if (wr_en)
        begin
            if (hit(paddr, HMC_IDX_RTV))
                rtv_r <= pwdata[7:0];
            if (hit(paddr, HMC_IDX_INCFG))
                incfg_r <= {pwdata[HMC_BIT_RV_FORMAT], pwdata[HMC_BIT_DC_BLOCK],
                            pwdata[HMC_BIT_IN_KIND]};
        end
    end

    // ------------------------------------------------------------------
    // launch bit: host writes, trigger pin and engine completion
    // ------------------------------------------------------------------
    // later assignments win, so the pin beats a host write and a host write beats done
    always_comb
    begin
        launch_nxt = launch_r;
        cancel_nxt = 1'b0;
        if (routine_done_i)
            launch_nxt = 1'b0;
        if (wr_en && hit(paddr, HMC_IDX_LAUNCH))
        begin
            if (!pwdata[HMC_BIT_LAUNCH] && launch_r)
                cancel_nxt = 1'b1; // host clearing the bit stops playback
            launch_nxt = pwdata[HMC_BIT_LAUNCH];
        end
        case (mode_r)
            HMC_MODE_EDGE:
            begin
                if (trig_rise && launch_r)
                begin
                    launch_nxt = 1'b0;
                    cancel_nxt = 1'b1;
                end
                else if (trig_rise)
                begin
                    launch_nxt = 1'b1;
                end
            end
            HMC_MODE_LEVEL:
            begin
                if (trig_rise && !launch_r)
                    launch_nxt = 1'b1;
                if (trig_fall && launch_r)
                begin
                    launch_nxt = 1'b0;
                    cancel_nxt = 1'b1;
                end
            end
            default:
            begin
                launch_nxt = launch_nxt; // other modes ignore the pin
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            launch_r <= 1'b0;
            cancel_o <= 1'b0;
        end
        else if (soft_clr || soft_start)
        begin
            launch_r <= 1'b0;
            cancel_o <= launch_r; // running playback is interrupted
        end
        else
        begin
            launch_r <= launch_nxt;
            cancel_o <= cancel_nxt;
        end
    end

    // ------------------------------------------------------------------
    // routine outcome flag
    // ------------------------------------------------------------------
    // only a one that the reader actually saw is cleared, so a result
    // landing between setup and access is never lost
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            outcome_r <= 1'b0;
        else if (soft_clr || soft_start)
            outcome_r <= 1'b0;
        else if (routine_done_i && (mode_r == HMC_MODE_DIAG || mode_r == HMC_MODE_CALIB))
            outcome_r <= routine_fail_i;
        else if (rd_en && hit(paddr, HMC_IDX_STATUS) && rd_out_r)
            outcome_r <= 1'b0;
    end

    // ------------------------------------------------------------------
    // outputs to the drive path
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            launch_o         <= 1'b0;
            mode_o           <= HMC_MODE_INTERNAL;
            standby_o        <= HMC_RST_STANDBY;
            drive_active_o   <= 1'b0;
            drive_analog_o   <= 1'b0;
            dc_block_o       <= 1'b0;
            drive_value_o    <= 8'h00;
            drive_unsigned_o <= 1'b0;
            playback_stop_o  <= 1'b0;
        end
        else
        begin
            launch_o       <= launch_r;
            mode_o         <= mode_r;
            standby_o      <= standby_r;
            // pin or value modes drive continuously outside standby
            drive_active_o <= !standby_r && !soft_busy &&
                              (mode_r == HMC_MODE_PWM || mode_r == HMC_MODE_AUDIO ||
                               mode_r == HMC_MODE_REALTIME);
            drive_analog_o   <= incfg_r[0];
            dc_block_o       <= incfg_r[1];
            drive_value_o    <= (mode_r == HMC_MODE_REALTIME) ? rtv_r : 8'h00;
            drive_unsigned_o <= incfg_r[2];
            playback_stop_o  <= soft_busy;
        end
    end
endmodule // hmc_mode_ctrl

/* hmc_pkg.sv */
// hmc_pkg: register indices, field positions, reset values and encodings
// for the haptic mode control register bank.
// assumes a 32-bit apb slave where byte address = 4 * register index.
package hmc_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] HMC_IDX_STATUS = 8'h00; // outcome flag lives here
    localparam logic [7:0] HMC_IDX_MODE   = 8'h01; // operating mode control
    localparam logic [7:0] HMC_IDX_RTV    = 8'h02; // realtime drive value
    localparam logic [7:0] HMC_IDX_LAUNCH = 8'h0C; // playback launch bit
    localparam logic [7:0] HMC_IDX_INCFG  = 8'h1D; // input and value format

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int HMC_BIT_SOFT_RST  = 7; // soft device reset
    localparam int HMC_BIT_STANDBY   = 6; // software standby
    localparam int HMC_MODE_MSB      = 2; // mode field top bit
    localparam int HMC_BIT_OUTCOME   = 3; // routine outcome flag in status
    localparam int HMC_BIT_LAUNCH    = 0; // launch bit
    localparam int HMC_BIT_IN_KIND   = 0; // 1 = analog input, 0 = pwm
    localparam int HMC_BIT_DC_BLOCK  = 1; // input dc block enable
    localparam int HMC_BIT_RV_FORMAT = 3; // 1 = unsigned drive value

    // ------------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------------
    localparam logic       HMC_RST_STANDBY = 1'b1;  // standby after reset
    localparam logic [2:0] HMC_RST_MODE    = 3'h0;  // internal trigger
    localparam logic [7:0] HMC_RST_RTV     = 8'h00; // drive value
    localparam logic [2:0] HMC_RST_INCFG   = 3'h0;  // pwm, dc, signed
    localparam int         HMC_SOFT_RST_CYCLES = 4; // soft reset duration

    // ------------------------------------------------------------------
    // operating modes (documented encoding)
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        HMC_MODE_INTERNAL = 3'h0, // host sets launch bit
        HMC_MODE_EDGE     = 3'h1, // trigger pin edges
        HMC_MODE_LEVEL    = 3'h2, // trigger pin level
        HMC_MODE_PWM      = 3'h3, // pwm or analog drive
        HMC_MODE_AUDIO    = 3'h4, // audio to vibration
        HMC_MODE_REALTIME = 3'h5, // realtime drive value
        HMC_MODE_DIAG     = 3'h6, // actuator diagnostic
        HMC_MODE_CALIB    = 3'h7  // auto calibration
    } hmc_mode_type;

    // soft reset sequencer states, gray along idle-clear-done
    typedef enum logic [1:0] {
        HMC_RS_IDLE  = 2'b00, // no reset running
        HMC_RS_CLEAR = 2'b01, // holding registers at defaults
        HMC_RS_DONE  = 2'b11  // releasing, bit self-clears
    } hmc_rs_type;

endpackage

/* hmc_pin_sync.sv */
// hmc_pin_sync: three-flop trigger pin synchroniser with edge pulses.
// assumes the pin is asynchronous to clk_sys_i.
`timescale 1ns/1ps
module hmc_pin_sync
(
    input  wire logic clk_sys_i, // system clock
    input  wire logic rst_i,     // async reset, active high
    input  wire logic pin_i,     // raw asynchronous pin
    output logic      level_o,   // accepted level
    output logic      rise_o,    // one-cycle pulse on rising change
    output logic      fall_o     // one-cycle pulse on falling change
);
    logic [2:0] stage_r; // [0] is metastable, read only by [1]

    // synchroniser chain
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            stage_r <= 3'h0;
        else
            stage_r <= {stage_r[1:0], pin_i};
    end

    // accept a change only once stages two and three agree
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            level_o <= 1'b0;
            rise_o  <= 1'b0;
            fall_o  <= 1'b0;
        end
        else
        begin
            rise_o <= (stage_r[1] == stage_r[2]) && stage_r[2] && !level_o;
            fall_o <= (stage_r[1] == stage_r[2]) && !stage_r[2] && level_o;
            if (stage_r[1] == stage_r[2])
                level_o <= stage_r[2];
        end
    end
endmodule // hmc_pin_sync

/* hmc_reset_seq.sv */
// hmc_reset_seq: soft reset sequencer, holds the bank at defaults.
// assumes start_i is a one-cycle pulse from the register write.
`timescale 1ns/1ps
module hmc_reset_seq
    import hmc_pkg::*;
#(
    parameter int CYCLES = HMC_SOFT_RST_CYCLES // cycles held in reset
)
(
    input  wire logic clk_sys_i, // system clock
    input  wire logic rst_i,     // async reset, active high
    input  wire logic start_i,   // soft reset requested
    output logic      clear_o,   // registers forced to defaults
    output logic      busy_o     // reset in progress, bit reads one
);
    hmc_rs_type  state_r; // sequencer state
    logic [15:0] cnt_r;   // cycles left in clear

    // state machine
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= HMC_RS_IDLE;
            cnt_r   <= 16'h0000;
        end
        else
        begin
            case (state_r)
                HMC_RS_IDLE:
                begin
                    if (start_i)
                    begin
                        state_r <= HMC_RS_CLEAR;
                        cnt_r   <= 16'(CYCLES - 1);
                    end
                end
                HMC_RS_CLEAR:
                begin
                    if (cnt_r == 16'h0000)
                        state_r <= HMC_RS_DONE;
                    else
                        cnt_r <= cnt_r - 16'h0001;
                end
                HMC_RS_DONE: state_r <= HMC_RS_IDLE; // bit self-clears
                default:     state_r <= HMC_RS_IDLE;
            endcase
        end
    end

    // outputs from flops, start_i lookahead makes them rise with the state
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            clear_o <= 1'b0;
            busy_o  <= 1'b0;
        end
        else
        begin
            clear_o <= (state_r == HMC_RS_IDLE) ? start_i : (state_r == HMC_RS_CLEAR);
            busy_o  <= (state_r == HMC_RS_IDLE) ? start_i : (state_r != HMC_RS_DONE);
        end
    end
endmodule // hmc_reset_seq

/* hmc_mode_ctrl_props.sv */
// hmc_mode_ctrl_props: concurrent checks on the mode control ports.
// assumes a bind into hmc_mode_ctrl.
`timescale 1ns/1ps
module hmc_mode_ctrl_props
    import hmc_pkg::*;
#(
    parameter int RST_CYCLES = HMC_SOFT_RST_CYCLES // soft reset length
)
(
    input wire logic          clk_sys_i,         // system clock
    input wire logic          rst_i,             // async reset
    input wire logic          trigger_input_pin, // trigger pin
    input wire logic          routine_done_i,    // engine done
    input wire logic          launch_o,          // launch bit
    input wire logic          cancel_o,          // cancel pulse
    input wire hmc_pkg::hmc_mode_type mode_o,    // current mode
    input wire logic          standby_o,         // standby
    input wire logic          drive_active_o,    // load driven
    input wire logic [7:0]    drive_value_o,     // drive value
    input wire logic          playback_stop_o    // soft reset running
);
    localparam int RST_MAX = RST_CYCLES + 8; // write edge and output flops
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // steps on the raw pin, before its synchroniser
    sequence s_edge_idle;
        mode_o == HMC_MODE_EDGE && !launch_o && $rose(trigger_input_pin);
    endsequence
    sequence s_edge_run;
        mode_o == HMC_MODE_EDGE && launch_o && $rose(trigger_input_pin);
    endsequence
    sequence s_level_fall;
        mode_o == HMC_MODE_LEVEL && launch_o && $fell(trigger_input_pin);
    endsequence
    a_reset_stops: assert property ($rose(playback_stop_o) |-> ##[0:2]
        (!launch_o && !drive_active_o)) else $error("soft reset left playback");
    a_reset_ends: assert property ($rose(playback_stop_o) |->
        ##[1:RST_MAX] !playback_stop_o) else $error("soft reset never ends");
    a_standby_idle: assert property (standby_o |-> !drive_active_o)
        else $error("load driven in standby");
    a_drive_modes: assert property (drive_active_o |-> mode_o inside
        {HMC_MODE_PWM, HMC_MODE_AUDIO, HMC_MODE_REALTIME}) else $error("drive mode");
    a_value_gate: assert property (mode_o != HMC_MODE_REALTIME |->
        drive_value_o == 8'h00) else $error("value outside realtime");
    a_edge_sets: assert property (s_edge_idle |-> ##[2:8] launch_o)
        else $error("edge did not launch");
    a_edge_cancel: assert property (s_edge_run |-> ##[2:8] cancel_o)
        else $error("second edge did not cancel");
    a_level_fall: assert property (s_level_fall |-> ##[2:8] cancel_o ##1
        !launch_o) else $error("fall did not cancel");
    a_cancel_cause: assert property (cancel_o |-> launch_o)
        else $error("cancel without launch");
    a_done_clears: assert property (routine_done_i && launch_o |->
        ##[1:3] !launch_o) else $error("launch kept after done");
endmodule // hmc_mode_ctrl_props
bind hmc_mode_ctrl hmc_mode_ctrl_props #(.RST_CYCLES(RST_CYCLES)) props_i (.clk_sys_i,
    .rst_i, .trigger_input_pin, .routine_done_i, .launch_o, .cancel_o, .mode_o,
    .standby_o, .drive_active_o, .drive_value_o, .playback_stop_o);

/* hmc_engine_model.sv */
// hmc_engine_model: stand-in for the playback and routine engine.
// assumes launch_i is the launch bit level.
`timescale 1ns/1ps
module hmc_engine_model
#(
    parameter int DELAY = 6 // done rises DELAY+1 cycles after launch
)
(
    input  wire logic clk_sys_i, // system clock
    input  wire logic rst_i,     // async reset
    input  wire logic en_i,      // engine answers launches
    input  wire logic fail_i,    // outcome to report
    input  wire logic launch_i,  // launch bit
    output logic      done_o,    // one-cycle done pulse
    output logic      fail_o     // outcome, valid with done
);
    logic [7:0] cnt_r; // cycles since launch, saturating
    // a cancel drops launch and so restarts the wait
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_r  <= 8'h00;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= en_i && launch_i && cnt_r == 8'(DELAY);
            cnt_r  <= launch_i ? cnt_r + {7'h00, cnt_r != 8'hFF} : 8'h00;
        end
    end
    // outcome is only valid with done
    assign fail_o = done_o ? fail_i : !fail_i;
endmodule // hmc_engine_model

/* hmc_mode_ctrl_tb_top.sv */
// hmc_mode_ctrl_tb_top: apb master, trigger pin and engine model.
// assumes a 10 MHz clock; waits for pready.
`timescale 1ns/1ps
module hmc_mode_ctrl_tb_top;
    import hmc_pkg::*;
    logic         clk_sys_i, rst_i, psel, penable, pwrite, pin, en, fail;
    logic         pready, pslverr, launch_o, cancel_o, standby_o, done, efail;
    logic         drive_active_o, drive_analog_o, dc_block_o, drive_unsigned_o, stop;
    logic [11:0]  paddr;       // byte address
    logic [31:0]  pwdata, prdata, v;
    logic [7:0]   drive_value_o;
    hmc_mode_type mode_o;
    logic [32:0]  exp_q[$];    // expected {pslverr, prdata}
    int           mismatches, n_tests;
    always #50 clk_sys_i = ~clk_sys_i;
    hmc_mode_ctrl hmc_mode_ctrl_i (.clk_sys_i, .rst_i, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .trigger_input_pin(pin),
        .routine_done_i(done), .routine_fail_i(efail), .launch_o, .cancel_o, .mode_o,
        .standby_o, .drive_active_o, .drive_analog_o, .dc_block_o, .drive_value_o,
        .drive_unsigned_o, .playback_stop_o(stop));
    hmc_engine_model #(.DELAY(6)) hmc_engine_model_i (.clk_sys_i, .rst_i, .en_i(en),
        .fail_i(fail), .launch_i(launch_o), .done_o(done), .fail_o(efail));
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // request held until the edge that samples pready high
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clk_sys_i);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, 2'b00, idx, 2'b00, d};
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do @(posedge clk_sys_i); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        xfer(1'b1, idx, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [32:0] e);
        exp_q.push_back(e);
        xfer(1'b0, idx, 32'h0);
    endtask
    // pin change, then synchroniser latency
    task automatic trig(input logic lv);
        @(posedge clk_sys_i) pin <= lv;
        repeat (10) @(posedge clk_sys_i);
    endtask
    // read data taken at the completing edge
    always @(posedge clk_sys_i)
        if (psel && penable && pready === 1'b1 && !pwrite)
            check(pslverr ? 33'h100000000 : {1'b0, prdata}, exp_q.pop_front());
    initial
    begin
        #600000;
        mismatches++;
        final_report;
    end
    initial
    begin
        {clk_sys_i, psel, penable, pwrite, pin, en, fail, paddr, pwdata} = '0;
        rst_i = 1'b1;
        v = $urandom(49010);
        v = $urandom;
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(8'h01, 33'h40);
        rd(8'h00, 33'h00);
        rd(8'h05, 33'h100000000);
        rd(8'h02, 33'h00);
        wr(8'h02, v);
        rd(8'h02, {25'h0, v[7:0]});
        for (int m = 0; m < 8; m++)
        begin
            wr(8'h01, 32'h38 | m); // reserved bits written high
            rd(8'h01, 33'(m));
            check(33'(drive_active_o), 33'(m > 2 && m < 6));
            if (m == 5) check(33'(drive_value_o), 33'(v[7:0]));
        end
        wr(8'h1D, 32'h0B);
        rd(8'h1D, 33'h0B);
        check(33'({drive_unsigned_o, dc_block_o, drive_analog_o}), 33'h7);
        wr(8'h01, 32'h01);
        trig(1'b1);
        trig(1'b0);
        check(33'(launch_o), 33'h1);
        trig(1'b1);
        check(33'(launch_o), 33'h0);
        wr(8'h01, 32'h02);
        trig(1'b0);
        check(33'(launch_o), 33'h0);
        trig(1'b1);
        check(33'(launch_o), 33'h1);
        trig(1'b0);
        check(33'(launch_o), 33'h0);
        {en, fail} <= 2'b11;
        for (int m = 6; m < 8; m++)
        begin
            wr(8'h01, 32'(m));
            wr(8'h0C, 32'h1);
            repeat (20) @(posedge clk_sys_i);
            rd(8'h0C, 33'h0);
            rd(8'h00, 33'h08);
            rd(8'h00, 33'h00);
        end
        en <= 1'b0;
        wr(8'h01, 32'h05);
        wr(8'h0C, 32'h1);
        wr(8'h01, 32'h80);
        rd(8'h01, 33'hC0);
        repeat (10) @(posedge clk_sys_i);
        rd(8'h01, 33'h40);
        rd(8'h02, 33'h00);
        rd(8'h0C, 33'h00);
        final_report;
    end
endmodule // hmc_mode_ctrl_tb_top
